// ---- logic/vgr_pkg.sv ----
`default_nettype none
package vgr_pkg;
	// -------------------------------------------------
	// I/O port addresses
	// -------------------------------------------------
	localparam logic [15:0] PORT_GLOBAL_EN   = 16'h0102;
	localparam logic [15:0] PORT_STAT2_MONO  = 16'h03ba;
	localparam logic [15:0] PORT_STAT2_COLOR = 16'h03da;
	localparam logic [15:0] PORT_ATTR        = 16'h03c0;
	localparam logic [15:0] PORT_MISC_WR     = 16'h03c2;
	localparam logic [15:0] PORT_BOARD_EN    = 16'h03c3;
	localparam logic [15:0] PORT_FEAT_RD     = 16'h03ca;
	localparam logic [15:0] PORT_MISC_RD     = 16'h03cc;
	localparam logic [15:0] PORT_GFX_INDEX   = 16'h03ce;
	localparam logic [15:0] PORT_GFX_DATA    = 16'h03cf;
	localparam logic [15:0] PORT_CARD_EN     = 16'h46e8;
	// -------------------------------------------------
	// Field positions
	// -------------------------------------------------
	localparam int MISC_VPOL   = 7;
	localparam int MISC_HPOL   = 6;
	localparam int MISC_PAGE   = 5;
	localparam int MISC_CLK_LO = 2;
	localparam int MISC_RAM    = 1;
	localparam int MISC_COLOR  = 0;
	localparam int FEAT_VSEL   = 3;
	localparam int CARD_SETUP  = 4;
	localparam int CARD_VIDEO  = 3;
	localparam int ATTR_SEL_LO = 4;
	localparam logic [4:0] ATTR_IDX_PLANE = 5'h12;
	localparam logic [3:0] GFX_LAST_IDX   = 4'h8;
	localparam int         GFX_REGS       = 9;
	// -------------------------------------------------
	// Fixed read values and reset values
	// -------------------------------------------------
	localparam logic [1:0] STAT2_FIXED  = 2'h2;
	localparam logic [7:0] UNMAPPED_RD  = 8'hff;
	localparam logic [7:0] MISC_RESET   = 8'h00;
	localparam logic [7:0] REG_RESET    = 8'h00;
	// -------------------------------------------------
	// Displayed line counts and clock choices
	// -------------------------------------------------
	localparam logic [9:0] LINES_NONE = 10'h000;
	localparam logic [9:0] LINES_400  = 10'h190;
	localparam logic [9:0] LINES_350  = 10'h15e;
	localparam logic [9:0] LINES_480  = 10'h1e0;
	typedef enum logic [1:0] {
		VGR_CLK_25M  = 2'h0,
		VGR_CLK_28M  = 2'h1,
		VGR_CLK_50M  = 2'h2,
		VGR_CLK_PLL  = 2'h3
	} vgr_clk_sel_t;
	// -------------------------------------------------
	// Host controller register map (AHB-Lite)
	// -------------------------------------------------
	localparam logic [7:0] HOST_CMD_OFS    = 8'h00;
	localparam logic [7:0] HOST_STATUS_OFS = 8'h04;
	localparam int CMD_DATA_LO = 16;
	localparam int CMD_WRITE   = 24;
	localparam int STAT_BUSY   = 0;
	localparam int STAT_RD_LO  = 8;
endpackage : vgr_pkg
`default_nettype wire

// ---- logic/vgr_io_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Legacy I/O port cycle between host controller and register bank
interface vgr_io_if;
	logic        io_req;   // One-cycle request pulse
	logic        io_wr;    // 1 write, 0 read
	logic [15:0] io_addr;  // Port address
	logic [7:0]  io_wdata; // Write data
	logic        io_ack;   // One-cycle answer pulse
	logic [7:0]  io_rdata; // Read data, valid with io_ack
	modport dev (input io_req, io_wr, io_addr, io_wdata, output io_ack, io_rdata);
	modport host (output io_req, io_wr, io_addr, io_wdata, input io_ack, io_rdata);
endinterface : vgr_io_if
`default_nettype wire

// ---- logic/vgr_regbank.sv ----
`timescale 1ns/1ns
`default_nettype none
module vgr_regbank (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Port bus from host
	vgr_io_if.dev            io,
	// Status from video logic, same clock
	input  wire logic        irq_pending,
	input  wire logic        vretrace,
	input  wire logic        display_off,
	input  wire logic [7:0]  pixel_out,
	// Pins from feature connector and sense comparator
	input  wire logic [1:0]  feature_pin,
	input  wire logic        sense_pin,
	// Decoded controls to the display engine
	output logic             vsync_neg,
	output logic             hsync_neg,
	output logic [9:0]       display_lines,
	output logic             page_high,
	output vgr_pkg::vgr_clk_sel_t clk_select,
	output logic             ram_enable,
	output logic             color_base,
	output logic             vsync_select,
	output logic [1:0]       feature_ctl,
	output logic             board_video_en,
	output logic             setup_mode,
	output logic             card_video_en,
	output logic             global_en,
	output logic [1:0]       attr_pair_sel,
	output logic [7:0]       gfx_regs [vgr_pkg::GFX_REGS]
);
	// -------------------------------------------------
	// Storage
	// -------------------------------------------------
	logic [7:0] misc_q;        // Miscellaneous output
	logic [7:0] feat_q;        // Feature control bits 3 and 1:0
	logic       board_q;       // Board video enable
	logic [1:0] card_q;        // Setup mode, card video enable
	logic       global_q;      // Global subsystem enable
	logic [4:0] attr_idx_q;    // Attribute index
	logic       attr_data_q;   // 1: next attribute write is data
	logic [1:0] attr_sel_q;    // Pixel pair from attribute 0x12
	logic [3:0] gfx_idx_q;     // Graphics index
	logic [7:0] gfx_q [vgr_pkg::GFX_REGS];
	logic [1:0] feat_s1_q, feat_s2_q;   // Pin synchroniser
	logic       sense_s1_q, sense_s2_q; // Pin synchroniser
	logic       ack_q;
	logic [7:0] rdata_q;

	// -------------------------------------------------
	// Access decode
	// -------------------------------------------------
	logic [15:0] stat2_port;  // Follows the mono/colour choice
	logic        wr, rd;
	logic        hit_stat2, hit_gfx_ok;
	logic [1:0]  pix_pair;
	assign stat2_port = misc_q[vgr_pkg::MISC_COLOR] ? vgr_pkg::PORT_STAT2_COLOR
		: vgr_pkg::PORT_STAT2_MONO;
	assign wr         = io.io_req & io.io_wr;
	assign rd         = io.io_req & ~io.io_wr;
	assign hit_stat2  = io.io_addr == stat2_port;
	assign hit_gfx_ok = gfx_idx_q <= vgr_pkg::GFX_LAST_IDX;
	// Two of the eight pixel bits, pair picked by attribute 0x12
	assign pix_pair   = pixel_out[{attr_sel_q, 1'b0} +: 2];

	// -------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------
	// Feature connector and sense are asynchronous levels
	always_ff @(posedge clk) begin
		if (rst) begin
			feat_s1_q  <= 2'h0;
			feat_s2_q  <= 2'h0;
			sense_s1_q <= 1'b0;
			sense_s2_q <= 1'b0;
		end else begin
			feat_s1_q  <= feature_pin;
			feat_s2_q  <= feat_s1_q;
			sense_s1_q <= sense_pin;
			sense_s2_q <= sense_s1_q;
		end
	end

	// -------------------------------------------------
	// Miscellaneous output register
	// -------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			misc_q <= vgr_pkg::MISC_RESET;
		end else if (wr && io.io_addr == vgr_pkg::PORT_MISC_WR) begin
			misc_q <= io.io_wdata;
		end
	end

	// -------------------------------------------------
	// Feature control and subsystem enables
	// -------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			feat_q   <= vgr_pkg::REG_RESET;
			board_q  <= 1'b0;
			card_q   <= 2'h0;
			global_q <= 1'b0;
		end else if (wr) begin
			// Reserved bits are dropped on the way in
			if (hit_stat2) begin
				feat_q <= {4'h0, io.io_wdata[vgr_pkg::FEAT_VSEL], 1'b0, io.io_wdata[1:0]};
			end
			if (io.io_addr == vgr_pkg::PORT_BOARD_EN) begin
				board_q <= io.io_wdata[0];
			end
			if (io.io_addr == vgr_pkg::PORT_CARD_EN) begin
				card_q <= {io.io_wdata[vgr_pkg::CARD_SETUP], io.io_wdata[vgr_pkg::CARD_VIDEO]};
			end
			if (io.io_addr == vgr_pkg::PORT_GLOBAL_EN) begin
				global_q <= io.io_wdata[0];
			end
		end
	end

	// -------------------------------------------------
	// Attribute index/data flip-flop
	// -------------------------------------------------
	// Only the plane select index is kept here; the rest of the
	// attribute file lives in the attribute controller.
	always_ff @(posedge clk) begin
		if (rst) begin
			attr_idx_q  <= 5'h00;
			attr_data_q <= 1'b0;
			attr_sel_q  <= 2'h0;
		end else if (rd && hit_stat2) begin
			attr_data_q <= 1'b0;
		end else if (wr && io.io_addr == vgr_pkg::PORT_ATTR) begin
			attr_data_q <= ~attr_data_q;
			if (!attr_data_q) begin
				attr_idx_q <= io.io_wdata[4:0];
			end else if (attr_idx_q == vgr_pkg::ATTR_IDX_PLANE) begin
				attr_sel_q <= io.io_wdata[vgr_pkg::ATTR_SEL_LO +: 2];
			end
		end
	end

	// -------------------------------------------------
	// Graphics controller index and data
	// -------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			gfx_idx_q <= 4'h0;
		end else if (wr && io.io_addr == vgr_pkg::PORT_GFX_INDEX) begin
			gfx_idx_q <= io.io_wdata[3:0];
		end
	end

	// Data writes beyond index 8 fall on nothing
	for (genvar g = 0; g < vgr_pkg::GFX_REGS; g++) begin : g_gfx
		always_ff @(posedge clk) begin
			if (rst) begin
				gfx_q[g] <= vgr_pkg::REG_RESET;
			end else if (wr && io.io_addr == vgr_pkg::PORT_GFX_DATA && gfx_idx_q == 4'(g)) begin
				gfx_q[g] <= io.io_wdata;
			end
		end
	end

	// -------------------------------------------------
	// Read mux and answer
	// -------------------------------------------------
	// Every request is answered two cycles later; status bits
	// are sampled at the request edge.
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q   <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ack_q <= io.io_req;
			if (rd) begin
				if (hit_stat2) begin
					rdata_q <= {2'h0, pix_pair, vretrace, vgr_pkg::STAT2_FIXED, display_off};
				end else begin
					unique case (io.io_addr)
						vgr_pkg::PORT_MISC_WR:
							rdata_q <= {irq_pending, feat_s2_q, sense_s2_q, 4'h0};
						vgr_pkg::PORT_FEAT_RD:
							rdata_q <= {2'h0, pix_pair, feat_q[3:0]};
						vgr_pkg::PORT_MISC_RD:
							rdata_q <= misc_q;
						vgr_pkg::PORT_BOARD_EN:
							rdata_q <= {7'h00, board_q};
						vgr_pkg::PORT_CARD_EN, vgr_pkg::PORT_GLOBAL_EN:
							rdata_q <= 8'h00; // Write-only bits read zero
						vgr_pkg::PORT_ATTR:
							rdata_q <= {3'h0, attr_idx_q};
						vgr_pkg::PORT_GFX_INDEX:
							rdata_q <= {4'h0, gfx_idx_q};
						vgr_pkg::PORT_GFX_DATA:
							rdata_q <= hit_gfx_ok ? gfx_q[gfx_idx_q] : 8'h00;
						default:
							rdata_q <= vgr_pkg::UNMAPPED_RD; // Floating bus
					endcase
				end
			end
		end
	end

	// -------------------------------------------------
	// Decoded control outputs
	// -------------------------------------------------
	// Registered once more so every output leaves a flop
	always_ff @(posedge clk) begin
		if (rst) begin
			vsync_neg     <= 1'b0;
			hsync_neg     <= 1'b0;
			display_lines <= vgr_pkg::LINES_NONE;
			page_high     <= 1'b0;
			clk_select    <= vgr_pkg::VGR_CLK_25M;
			ram_enable    <= 1'b0;
			color_base    <= 1'b0;
		end else begin
			vsync_neg  <= misc_q[vgr_pkg::MISC_VPOL];
			hsync_neg  <= misc_q[vgr_pkg::MISC_HPOL];
			unique case (misc_q[7:6])
				2'h1:    display_lines <= vgr_pkg::LINES_400;
				2'h2:    display_lines <= vgr_pkg::LINES_350;
				2'h3:    display_lines <= vgr_pkg::LINES_480;
				default: display_lines <= vgr_pkg::LINES_NONE; // Reserved code
			endcase
			// Meaningful to memory logic only in odd/even mode
			page_high  <= misc_q[vgr_pkg::MISC_PAGE];
			clk_select <= vgr_pkg::vgr_clk_sel_t'(misc_q[vgr_pkg::MISC_CLK_LO +: 2]);
			ram_enable <= misc_q[vgr_pkg::MISC_RAM];
			color_base <= misc_q[vgr_pkg::MISC_COLOR];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			vsync_select   <= 1'b0;
			feature_ctl    <= 2'h0;
			board_video_en <= 1'b0;
			setup_mode     <= 1'b0;
			card_video_en  <= 1'b0;
			global_en      <= 1'b0;
			attr_pair_sel  <= 2'h0;
			io.io_ack      <= 1'b0;
			io.io_rdata    <= 8'h00;
		end else begin
			vsync_select   <= feat_q[vgr_pkg::FEAT_VSEL];
			feature_ctl    <= feat_q[1:0];
			board_video_en <= board_q;
			setup_mode     <= card_q[1];
			card_video_en  <= card_q[0];
			global_en      <= global_q;
			attr_pair_sel  <= attr_sel_q;
			io.io_ack      <= ack_q;
			io.io_rdata    <= rdata_q;
		end
	end

	for (genvar g = 0; g < vgr_pkg::GFX_REGS; g++) begin : g_gfx_out
		always_ff @(posedge clk) begin
			if (rst) begin
				gfx_regs[g] <= vgr_pkg::REG_RESET;
			end else begin
				gfx_regs[g] <= gfx_q[g];
			end
		end
	end
endmodule : vgr_regbank
`default_nettype wire

// ---- logic/vgr_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module vgr_host (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Port bus to register bank
	vgr_io_if.host           io
);
	typedef enum logic {ST_IDLE, ST_WAIT} vgr_host_st_t;

	// -------------------------------------------------
	// State
	// -------------------------------------------------
	vgr_host_st_t st_q;
	logic         wr_pend_q;  // Data phase of a write pending
	logic [7:0]   wofs_q;     // Offset of that write
	logic [7:0]   last_rd_q;  // Last port read data
	logic         start;
	assign start = wr_pend_q && wofs_q == vgr_pkg::HOST_CMD_OFS && st_q == ST_IDLE;

	// -------------------------------------------------
	// AHB address phase capture
	// -------------------------------------------------
	// Always zero wait states; hsize is not checked since only
	// whole words are issued.
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			wofs_q    <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_q <= 1'b0;
			if (hsel && hready && htrans[1]) begin
				wr_pend_q <= hwrite;
				wofs_q    <= haddr[7:0];
				if (!hwrite) begin
					hrdata <= (haddr[7:0] == vgr_pkg::HOST_STATUS_OFS)
						? {16'h0000, last_rd_q, 7'h00, st_q == ST_WAIT} : 32'h0000_0000;
				end
			end
		end
	end

	// -------------------------------------------------
	// Port cycle sequencer
	// -------------------------------------------------
	// A command written while busy is dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q        <= ST_IDLE;
			io.io_req   <= 1'b0;
			io.io_wr    <= 1'b0;
			io.io_addr  <= 16'h0000;
			io.io_wdata <= 8'h00;
			last_rd_q   <= 8'h00;
		end else begin
			io.io_req <= 1'b0;
			unique case (st_q)
				ST_IDLE: begin
					if (start) begin
						io.io_req   <= 1'b1;
						io.io_addr  <= hwdata[15:0];
						io.io_wdata <= hwdata[vgr_pkg::CMD_DATA_LO +: 8];
						io.io_wr    <= hwdata[vgr_pkg::CMD_WRITE];
						st_q        <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (io.io_ack) begin
						if (!io.io_wr) begin
							last_rd_q <= io.io_rdata;
						end
						st_q <= ST_IDLE;
					end
				end
			endcase
		end
	end
endmodule : vgr_host
`default_nettype wire

// ---- sim/vgr_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module vgr_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Port bus
	input wire logic        io_req,
	input wire logic        io_wr,
	input wire logic [15:0] io_addr,
	input wire logic [7:0]  io_wdata,
	input wire logic        io_ack,
	input wire logic [7:0]  io_rdata
);
	// ----
	// Shadows of stored fields
	// ----
	logic [7:0] misc_q;  // Last misc value written
	logic [3:0] feat_q;  // Feature bits as read back
	logic       board_q; // Board enable bit
	logic [7:0] gidx_q;  // Graphics index
	logic       wr_c;    // Write taken
	logic       rd_c;    // Read taken
	logic       st2_c;   // Live status two port
	assign wr_c = io_req && io_wr;
	assign rd_c = io_req && !io_wr;
	assign st2_c = io_addr == (misc_q[0] ? 16'h03da : 16'h03ba);
	// Only one request is ever in flight, so shadows may follow the request edge
	always_ff @(posedge clk) begin
		if (rst) begin
			misc_q <= 8'h00;
			feat_q <= 4'h0;
			board_q <= 1'b0;
			gidx_q <= 8'h00;
		end else if (wr_c) begin
			if (io_addr == 16'h03c2) misc_q <= io_wdata;
			if (st2_c) feat_q <= {io_wdata[3], 1'b0, io_wdata[1:0]};
			if (io_addr == 16'h03c3) board_q <= io_wdata[0];
			// The index register keeps four bits, so 0x10 aliases to index 0
			if (io_addr == 16'h03ce) gidx_q <= {4'h0, io_wdata[3:0]};
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	ack_two_cycles_a: assert property (io_req |-> ##1 !io_ack ##1 io_ack) else $error("answer not two cycles on");
	stat1_low_zero_a: assert property (rd_c && io_addr == 16'h03c2 |-> ##2 io_rdata[3:0] == 4'h0)
		else $error("status one low bits set");
	misc_readback_a: assert property (rd_c && io_addr == 16'h03cc |-> ##2 io_rdata == $past(misc_q, 2))
		else $error("misc readback wrong");
	stat2_top_a: assert property (rd_c && st2_c |-> ##2 io_rdata[7:6] == 2'h0)
		else $error("status two top bits set");
	stat2_fixed_a: assert property (rd_c && st2_c |-> ##2 io_rdata[2:1] == 2'h2)
		else $error("status two fixed bits wrong");
	feat_readback_a: assert property (rd_c && io_addr == 16'h03ca |->
		##2 {io_rdata[7:6], io_rdata[3:0]} == {2'h0, feat_q})
		else $error("feature readback wrong");
	board_en_a: assert property (rd_c && io_addr == 16'h03c3 |-> ##2 io_rdata == {7'h00, board_q})
		else $error("board enable readback wrong");
	card_wo_a: assert property (rd_c && io_addr == 16'h46e8 |-> ##2 io_rdata[4:3] == 2'h0)
		else $error("card enable bits readable");
	global_wo_a: assert property (rd_c && io_addr == 16'h0102 |-> ##2 !io_rdata[0])
		else $error("global enable readable");
	gfx_range_a: assert property (rd_c && io_addr == 16'h03cf && gidx_q > 8'h08 |-> ##2 io_rdata == 8'h00)
		else $error("graphics index out of range read nonzero");
endmodule : vgr_checker
`default_nettype wire

// ---- sim/tb_vga_general_register_ports.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_vga_general_register_ports;
	// ----
	// Stimulus and observed signals
	// ----
	logic        clk, rst;          // 20 MHz clock, sync reset
	logic        hsel, hwrite;      // AHB control
	logic [1:0]  htrans;            // AHB transfer kind
	logic [2:0]  hsize;             // Always a word
	logic [31:0] haddr, hwdata;     // AHB address and write data
	logic        hreadyout, hresp;  // Slave answer
	logic [31:0] hrdata;            // Slave read data
	logic        irq, vret, doff;   // Video status levels
	logic [7:0]  pix;               // Attribute pixel output
	logic [1:0]  fpin;              // Feature connector pins
	logic        sense;             // Monitor sense
	logic        vneg, hneg, page, ram, color, vsel, board, setup, card, glob;
	logic [9:0]  lines;             // Displayed line count
	logic [1:0]  fctl, psel;        // Feature control, pair select
	vgr_pkg::vgr_clk_sel_t csel;    // Video clock choice
	logic [7:0]  gfx_view [vgr_pkg::GFX_REGS];
	logic [7:0]  junk, r;           // Read results
	int          error_cnt = 0;
	int          samples_checked = 0;
	vgr_io_if io_bus ();
	vgr_host vgr_host_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .io(io_bus));
	vgr_regbank vgr_regbank_i (.clk(clk), .rst(rst), .io(io_bus), .irq_pending(irq), .vretrace(vret),
		.display_off(doff), .pixel_out(pix), .feature_pin(fpin), .sense_pin(sense), .vsync_neg(vneg),
		.hsync_neg(hneg), .display_lines(lines), .page_high(page), .clk_select(csel), .ram_enable(ram),
		.color_base(color), .vsync_select(vsel), .feature_ctl(fctl), .board_video_en(board),
		.setup_mode(setup), .card_video_en(card), .global_en(glob), .attr_pair_sel(psel), .gfx_regs(gfx_view));
	vgr_checker vgr_checker_i (.clk(clk), .rst(rst), .io_req(io_bus.io_req), .io_wr(io_bus.io_wr),
		.io_addr(io_bus.io_addr), .io_wdata(io_bus.io_wdata), .io_ack(io_bus.io_ack), .io_rdata(io_bus.io_rdata));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ----
	// Shared tasks
	// ----
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One AHB single word transfer; the slave decides the wait
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	// Port cycle through the command register, then wait for it to finish
	task automatic io(input logic w, input logic [15:0] p, input logic [7:0] d, output logic [7:0] q);
		logic [31:0] s;
		int n;
		ahb(1'b1, vgr_pkg::HOST_CMD_OFS, {7'h00, w, d, p}, s);
		n = 0;
		while (io_bus.io_ack !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		do begin
			ahb(1'b0, vgr_pkg::HOST_STATUS_OFS, 32'h0, s);
			n++;
		end while (s[vgr_pkg::STAT_BUSY] !== 1'b0 && n < 40);
		// A cycle that never finishes is a failure, not a silent skip
		if (s[vgr_pkg::STAT_BUSY] !== 1'b0) begin
			error_cnt++;
			$display("BAD port cycle %h expected 0 seen %b", p, s[vgr_pkg::STAT_BUSY]);
		end
		q = s[15:8];
	endtask
	task automatic wr(input logic [15:0] p, input logic [7:0] d);
		io(1'b1, p, d, junk);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_status_one();
		irq <= 1'b1;
		fpin <= 2'h2;
		sense <= 1'b1;
		io(1'b0, 16'h03c2, 8'h00, r);
		chk("status one", 16'h00d0, 16'(r));
		irq <= 1'b0;
		fpin <= 2'h1;
		sense <= 1'b0;
		io(1'b0, 16'h03c2, 8'h00, r);
		chk("status one", 16'h0020, 16'(r));
		$display("test status_one done");
	endtask
	task automatic t_misc();
		logic [7:0] v;
		logic [9:0] le [4];
		le = '{vgr_pkg::LINES_NONE, vgr_pkg::LINES_400, vgr_pkg::LINES_350, vgr_pkg::LINES_480};
		for (int k = 0; k < 4; k++) begin
			v = {k[1:0], k[0], 1'b0, k[1:0], ~k[1], k[0]};
			wr(16'h03c2, v);
			io(1'b0, 16'h03cc, 8'h00, r);
			chk("misc", 16'(v), 16'(r));
			chk("misc out", 16'({v[7:5], v[3:0]}), 16'({vneg, hneg, page, csel, ram, color}));
			chk("lines", 16'(le[k]), 16'(lines));
		end
		$display("test misc done");
	endtask
	task automatic t_status_two();
		vret <= 1'b1;
		doff <= 1'b0;
		pix <= 8'h4b;
		io(1'b0, 16'h03ba, 8'h00, r);
		chk("mono port", 16'h00ff, 16'(r));
		io(1'b0, 16'h03da, 8'h00, r);
		wr(16'h03c0, 8'h12);
		io(1'b0, 16'h03da, 8'h00, r);
		wr(16'h03c0, 8'h12);
		wr(16'h03c0, 8'h30);
		chk("pair select", 16'h0003, 16'(psel));
		io(1'b0, 16'h03da, 8'h00, r);
		chk("status two", 16'h001c, 16'(r));
		vret <= 1'b0;
		doff <= 1'b1;
		io(1'b0, 16'h03da, 8'h00, r);
		chk("status two", 16'h0015, 16'(r));
		wr(16'h03da, 8'hff);
		io(1'b0, 16'h03ca, 8'h00, r);
		chk("feature", 16'h001b, 16'(r));
		wr(16'h03ba, 8'h00);
		io(1'b0, 16'h03ca, 8'h00, r);
		chk("feature", 16'h001b, 16'(r));
		wr(16'h03da, 8'hf5);
		io(1'b0, 16'h03ca, 8'h00, r);
		chk("feature", 16'h0011, 16'(r));
		chk("feature out", 16'h0001, 16'({vsel, fctl}));
		// Another pair: select 1 picks pixel bits 3:2
		wr(16'h03c0, 8'h12);
		wr(16'h03c0, 8'h10);
		io(1'b0, 16'h03c0, 8'h00, r);
		chk("attr index", 16'h0012, 16'(r));
		io(1'b0, 16'h03ca, 8'h00, r);
		chk("feature", 16'h0021, 16'(r));
		$display("test status_two done");
	endtask
	task automatic t_enables();
		wr(16'h03c3, 8'hff);
		io(1'b0, 16'h03c3, 8'h00, r);
		chk("board", 16'h0101, {r, 7'h00, board});
		wr(16'h03c3, 8'hfe);
		chk("board", 16'h0000, 16'(board));
		wr(16'h46e8, 8'h10);
		io(1'b0, 16'h46e8, 8'h00, r);
		chk("card", 16'h0002, {r, 6'h00, setup, card});
		wr(16'h46e8, 8'h08);
		chk("card", 16'h0001, 16'({setup, card}));
		wr(16'h0102, 8'hff);
		io(1'b0, 16'h0102, 8'h00, r);
		chk("global", 16'h0001, {r, 7'h00, glob});
		wr(16'h0102, 8'hfe);
		chk("global", 16'h0000, 16'(glob));
		$display("test enables done");
	endtask
	task automatic t_gfx();
		for (int i = 0; i < 10; i++) begin
			wr(16'h03ce, 8'(i));
			wr(16'h03cf, 8'h50 + 8'(i));
		end
		for (int i = 0; i < 10; i++) begin
			wr(16'h03ce, 8'(i));
			io(1'b0, 16'h03ce, 8'h00, r);
			chk("gfx index", 16'(i), 16'(r));
			io(1'b0, 16'h03cf, 8'h00, r);
			chk("gfx data", 16'(i < 9 ? 8'h50 + 8'(i) : 8'h00), 16'(r));
			if (i < 9) chk("gfx out", 16'(8'h50 + 8'(i)), 16'(gfx_view[i]));
		end
		$display("test gfx done");
	endtask
	task automatic t_host();
		logic [31:0] s;
		ahb(1'b0, 8'h08, 32'h0, s);
		chk("host spare", 16'h0000, s[15:0]);
		io(1'b0, 16'h0300, 8'h00, r);
		chk("unmapped", 16'h00ff, 16'(r));
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		io(1'b0, 16'h03cc, 8'h00, r);
		chk("misc reset", 16'(vgr_pkg::MISC_RESET), 16'(r));
		chk("colour base", 16'(vgr_pkg::MISC_RESET[vgr_pkg::MISC_COLOR]), 16'(color));
		chk("hresp", 16'h0000, 16'(hresp));
		$display("test host done");
	endtask
	// ----
	// Verdict
	// ----
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		close_out();
	end
	initial begin
		rst <= 1'b1;
		hsel <= 1'b1;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hsize <= 3'h2;
		haddr <= 32'h0;
		hwdata <= 32'h0;
		irq <= 1'b0;
		vret <= 1'b0;
		doff <= 1'b0;
		pix <= 8'h00;
		fpin <= 2'h0;
		sense <= 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_status_one();
		t_misc();
		t_status_two();
		t_enables();
		t_gfx();
		t_host();
		close_out();
	end
endmodule : tb_vga_general_register_ports
`default_nettype wire
